// File: spi_cs_timing_pkg.sv
package spi_cs_timing_pkg;
    // bus geometry
    localparam int ADDR_W = 6;
    // register byte offsets
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_TXWORD = 6'h04;
    localparam logic [5:0] OFF_FLAGS = 6'h08;
    localparam logic [5:0] OFF_RXBUF = 6'h0C;
    localparam logic [5:0] OFF_EMU = 6'h10;
    localparam logic [5:0] OFF_DELAYS = 6'h14;
    localparam logic [5:0] OFF_FMT0 = 6'h18;
    // field positions in control and flag registers
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_FMT_LSB = 1;
    localparam int FLG_TO_BIT = 0;
    localparam int FLG_DS_BIT = 1;
    localparam int FLG_BUSY_BIT = 8;
    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DELAYS_RESET = 32'h0000_0000;
    localparam logic [31:0] FMT_RESET = 32'h0000_0000;
    // writable bits of a format register, reserved ones read zero
    localparam logic [31:0] FMT_WMASK = 32'h3FF7_FF1F;
    // extra system cycles added to the setup and hold counts
    localparam logic [8:0] SETUP_EXTRA = 9'h002;
    localparam logic [8:0] HOLD_EXTRA = 9'h001;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one format register as laid out on the bus
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [5:0] inter_word_delay;
        logic parity_odd_select;
        logic parity_en;
        logic wait_for_handshake;
        logic lsb_first_select;
        logic rsv_mid;
        logic skip_cs_timers;
        logic polarity;
        logic phase;
        logic [7:0] prescale;
        logic [2:0] rsv_lo;
        logic [4:0] charlen;
    } fmt_s;

    // the delay register
    typedef struct packed {
        logic [7:0] cs_setup_delay;
        logic [7:0] cs_hold_delay;
        logic [7:0] desync_timeout;
        logic [7:0] handshake_timeout;
    } delay_s;

    // transfer sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_XFER = 5'b01000,
        ST_HOLD = 5'b10000
    } state_e;
endpackage : spi_cs_timing_pkg

// File: spi_cs_timing.sv
// Function
// - mirror read returns buffer, clears nothing
// - mirror upper half reads zero, ignores writes
// - master setup delay is field plus two
// - zero setup field means no setup delay
// - phase one adds half period before clock
// - master hold delay is field plus one
// - zero hold field means no hold delay
// - phase zero adds half period after clock
// - setup count ignores slave handshake line
// - chip select held until hold count ends
// - late handshake release after deselect flags desync
// - early handshake release flags desync
// - handshake wait limited in serial clocks
// - handshake time-out sets time-out flag
// - time-out cancels request, marks buffer status
// - skip bit drops both setup and hold
// - wait bit waits for handshake or aborts
// - phase decides launch and capture edges
`timescale 1ns/1ps
`default_nettype none
module spi_cs_timing (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [spi_cs_timing_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [spi_cs_timing_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic chip_select_line_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic slave_handshake_line_n
);
    import spi_cs_timing_pkg::*;

    // software state
    logic [31:0] ctrl; // master enable and format select
    delay_s delays; // setup, hold and time-out fields
    fmt_s fmt [4]; // four transfer formats
    fmt_s act; // format latched for the running frame
    // sequencer
    state_e st;
    state_e next_st;
    logic [8:0] cyc; // system cycles spent in the current state
    logic [7:0] div; // half serial period divider
    logic ptog; // second half of a serial period
    logic [5:0] h; // half period index inside a frame
    logic [8:0] to_cnt; // serial periods spent in setup and wait since select went active
    logic watch; // waiting for handshake release after deselect
    logic [8:0] wcnt; // serial periods since deselect
    // datapath
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [15:0] rx_word;
    logic rx_empty;
    logic rx_to;
    logic rx_ds;
    logic flag_to;
    logic flag_ds;
    // pin synchronisers
    logic [1:0] miso_sync;
    logic [1:0] hs_sync;
    logic hs_prev;

    // pins cross two flops, only stage two is read downstream
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            miso_sync <= 2'h0;
            hs_sync <= 2'h3;
            hs_prev <= 1'b1;
        end else begin
            miso_sync <= {miso_sync[0], miso};
            hs_sync <= {hs_sync[0], slave_handshake_line_n};
            hs_prev <= hs_sync[1];
        end
    end
    wire hs_active = ~hs_sync[1]; // slave handshake asserted (low)
    wire hs_rise = hs_sync[1] & ~hs_prev; // slave released handshake

    // bus decode
    wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire rd_take = s_axi_arvalid & ~s_axi_rvalid;
    wire [5:0] wa = 6'(s_axi_awaddr);
    wire [5:0] ra = 6'(s_axi_araddr);
    wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [31:0] wbits = s_axi_wdata & wmask;
    wire wsel_ctrl = wr_take && wa == OFF_CTRL;
    wire wsel_tx = wr_take && wa == OFF_TXWORD;
    wire wsel_flg = wr_take && wa == OFF_FLAGS;
    wire wsel_dly = wr_take && wa == OFF_DELAYS;
    wire [5:0] fmt_off = wa - OFF_FMT0;
    wire wsel_fmt = wr_take && wa >= OFF_FMT0 && fmt_off < 6'h10;
    // the mirror and buffer are read-only, writes there are ignored
    wire wmapped = wsel_ctrl | wsel_tx | wsel_flg | wsel_dly | wsel_fmt
                   | (wa == OFF_RXBUF) | (wa == OFF_EMU);
    wire rsel_buf = rd_take && ra == OFF_RXBUF;
    wire rsel_emu = rd_take && ra == OFF_EMU;
    wire [5:0] rfmt_off = ra - OFF_FMT0;
    wire rfmt_hit = ra >= OFF_FMT0 && rfmt_off < 6'h10;

    // status words
    wire busy = st != ST_IDLE;
    wire [31:0] buf_word = {rx_empty, 3'h0, rx_ds, 1'b0, rx_to, 9'h000, rx_word};
    wire [31:0] flag_word = {23'h0, busy, 6'h0, flag_ds, flag_to};
    wire [31:0] emu_word = {16'h0000, rx_word};
    wire [31:0] rd_mux = (ra == OFF_CTRL) ? ctrl :
                         (ra == OFF_FLAGS) ? flag_word :
                         (ra == OFF_RXBUF) ? buf_word :
                         (ra == OFF_EMU) ? emu_word :
                         (ra == OFF_DELAYS) ? delays :
                         rfmt_hit ? fmt[rfmt_off[3:2]] : 32'h0000_0000;
    wire rd_ok = (ra == OFF_CTRL) | (ra == OFF_FLAGS) | (ra == OFF_RXBUF)
                 | (ra == OFF_EMU) | (ra == OFF_DELAYS) | rfmt_hit
                 | (ra == OFF_TXWORD);

    // handshake outputs follow the response registers
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = ~s_axi_rvalid;

    // write and read responses, one outstanding each
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wmapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata <= rd_mux;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control and delay registers, byte lanes honoured
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= CTRL_RESET;
            delays <= DELAYS_RESET;
        end else begin
            if (wsel_ctrl)
                ctrl <= (ctrl & ~wmask) | (wbits & 32'h0000_0007);
            if (wsel_dly)
                delays <= (delays & ~wmask) | wbits;
        end
    end

    // one format register per slot, reserved bits held at zero
    for (genvar g = 0; g < 4; g++) begin : g_fmt
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn)
                fmt[g] <= FMT_RESET;
            else if (wsel_fmt && fmt_off[3:2] == 2'(g))
                fmt[g] <= (fmt[g] & ~(wmask & FMT_WMASK)) | (wbits & FMT_WMASK);
        end
    end

    // a word write starts a frame; refused while busy or as slave
    wire master = ctrl[CTRL_MASTER_BIT];
    wire go = wsel_tx & ~busy & master;
    wire fmt_s nf = fmt[ctrl[CTRL_FMT_LSB +: 2]];
    wire setup_on = ~nf.skip_cs_timers && delays.cs_setup_delay != 8'h00;
    wire hold_on = ~act.skip_cs_timers && delays.cs_hold_delay != 8'h00;
    wire [8:0] setup_last = {1'b0, delays.cs_setup_delay} + SETUP_EXTRA - 9'h001;
    wire [8:0] hold_last = {1'b0, delays.cs_hold_delay} + HOLD_EXTRA - 9'h001;
    // one extra half period on the phase's side
    wire [5:0] h_last = {act.charlen, 1'b0};
    wire half_tick = div == act.prescale;
    wire period_tick = half_tick & ptog;
    wire hs_timeout = to_cnt >= {1'b0, delays.handshake_timeout};

    // sequencer next state
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: begin
                if (go)
                    next_st = setup_on ? ST_SETUP :
                              (nf.wait_for_handshake ? ST_WAIT : ST_XFER);
            end
            ST_SETUP: begin
                if (cyc == setup_last)
                    next_st = act.wait_for_handshake ? ST_WAIT : ST_XFER;
            end
            ST_WAIT: begin
                if (hs_active)
                    next_st = ST_XFER;
                else if (hs_timeout)
                    next_st = ST_IDLE;
            end
            ST_XFER: begin
                if (half_tick && h == h_last)
                    next_st = hold_on ? ST_HOLD : ST_IDLE;
            end
            ST_HOLD: begin
                if (cyc == hold_last)
                    next_st = ST_IDLE;
            end
            default: next_st = ST_IDLE;
        endcase
    end

    wire moving = next_st != st;
    wire to_ev = st == ST_WAIT && next_st == ST_IDLE;
    wire xfer_done = st == ST_XFER && moving;
    wire frame_end = (st == ST_XFER || st == ST_HOLD) && next_st == ST_IDLE;
    wire [5:0] e = act.phase ? h - 6'h01 : h;
    wire edge_now = st == ST_XFER && half_tick &&
                    (act.phase ? h != 6'h00 : h != h_last);
    wire sample = edge_now && (e[0] != act.phase);
    wire shift = edge_now && (e[0] == act.phase) && e != 6'h00;
    wire early_ds = st == ST_XFER && act.wait_for_handshake && hs_rise;
    wire late_ds = watch && st == ST_IDLE && period_tick && hs_active &&
                   wcnt >= {1'b0, delays.desync_timeout};
    wire ds_ev = early_ds | late_ds;
    wire [15:0] tx_aligned = s_axi_wdata[15:0] << 5'(5'h10 - nf.charlen);

    // state, cycle count and serial timebase; both restart per state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= ST_IDLE;
            cyc <= 9'h000;
            div <= 8'h00;
            ptog <= 1'b0;
        end else begin
            st <= next_st;
            cyc <= moving ? 9'h000 : cyc + 9'h001;
            div <= (moving || half_tick) ? 8'h00 : div + 8'h01;
            ptog <= moving ? 1'b0 : ptog ^ half_tick;
        end
    end

    // time-out counters restart at select and at frame end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            to_cnt <= 9'h000;
            watch <= 1'b0;
            wcnt <= 9'h000;
        end else begin
            if (go)
                to_cnt <= 9'h000;
            else if (period_tick && (st == ST_SETUP || st == ST_WAIT))
                to_cnt <= to_cnt + 9'h001;
            if (frame_end) begin
                watch <= master & act.wait_for_handshake;
                wcnt <= 9'h000;
            end else if (go || late_ds || (watch && !hs_active)) begin
                watch <= 1'b0;
            end else if (watch && period_tick) begin
                wcnt <= wcnt + 9'h001;
            end
        end
    end

    // pins and shift registers; select drops at once on a time-out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act <= FMT_RESET;
            chip_select_line_n <= 1'b1;
            sclk <= 1'b0;
            mosi <= 1'b0;
            tx_sh <= 16'h0000;
            rx_sh <= 16'h0000;
            h <= 6'h00;
        end else if (go) begin
            act <= nf;
            chip_select_line_n <= 1'b0;
            sclk <= nf.polarity;
            tx_sh <= tx_aligned;
            mosi <= tx_aligned[15];
            rx_sh <= 16'h0000;
            h <= 6'h00;
        end else begin
            if (busy && next_st == ST_IDLE)
                chip_select_line_n <= 1'b1;
            if (edge_now)
                sclk <= ~sclk;
            if (sample)
                rx_sh <= {rx_sh[14:0], miso_sync[1]};
            if (shift) begin
                tx_sh <= {tx_sh[14:0], 1'b0};
                mosi <= tx_sh[14];
            end
            if (st == ST_XFER && half_tick)
                h <= h + 6'h01;
        end
    end

    // receive buffer; a buffer read clears, a mirror read does not
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_word <= 16'h0000;
            rx_empty <= 1'b1;
            rx_to <= 1'b0;
            rx_ds <= 1'b0;
        end else begin
            if (xfer_done) begin
                rx_word <= rx_sh;
                rx_empty <= 1'b0;
            end else if (rsel_buf) begin
                rx_empty <= 1'b1;
            end
            if (to_ev)
                rx_to <= 1'b1;
            else if (rsel_buf)
                rx_to <= 1'b0;
            if (ds_ev)
                rx_ds <= 1'b1;
            else if (rsel_buf)
                rx_ds <= 1'b0;
        end
    end

    // sticky flags, write one to clear, a new event wins the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_to <= 1'b0;
            flag_ds <= 1'b0;
        end else begin
            if (to_ev)
                flag_to <= 1'b1;
            else if (wsel_flg && wbits[FLG_TO_BIT])
                flag_to <= 1'b0;
            if (ds_ev)
                flag_ds <= 1'b1;
            else if (wsel_flg && wbits[FLG_DS_BIT])
                flag_ds <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_mirror_keep:
        assert property (rsel_emu && !xfer_done && !to_ev && !ds_ev && !rsel_buf
            |=> $stable(rx_empty) && $stable(rx_to) && $stable(rx_ds))
        else $error("mirror read changed buffer status");
    a_emu_upper:
        assert property (rsel_emu |=> s_axi_rdata[31:16] == 16'h0000 &&
            s_axi_rdata[15:0] == $past(rx_word))
        else $error("mirror read wrong");
    a_setup_len:
        assert property (st == ST_SETUP && moving
            |-> cyc == {1'b0, delays.cs_setup_delay} + 9'h001)
        else $error("setup length wrong");
    a_no_setup:
        assert property (go && !setup_on |=> st != ST_SETUP && !chip_select_line_n)
        else $error("setup inserted when disabled");
    a_hold_len:
        assert property (st == ST_HOLD && moving
            |=> chip_select_line_n && $past(cyc) == {1'b0, delays.cs_hold_delay})
        else $error("hold length wrong");
    a_cs_held:
        assert property (st == ST_HOLD |-> !chip_select_line_n ##1 st != ST_IDLE
            || chip_select_line_n)
        else $error("select released early");
    a_setup_clk_idle:
        assert property (st == ST_SETUP |-> sclk == act.polarity)
        else $error("serial clock moved during setup");
    a_timeout_flag:
        assert property (to_ev |=> flag_to && rx_to && chip_select_line_n
            && st == ST_IDLE)
        else $error("time-out not flagged");
    a_early_desync:
        assert property (early_ds |=> flag_ds && rx_ds)
        else $error("early release not flagged");
endmodule : spi_cs_timing
`default_nettype wire

// File: spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input wire logic clk,
    input wire logic chip_select_line_n,
    input wire logic mosi,
    input wire logic hs_on,
    input wire logic hs_stuck,
    input wire logic hs_drop,
    output logic miso,
    output logic slave_handshake_line_n
);
    // a released data line wanders every cycle, so stale values never pass
    logic idle_bit = 1'b0;
    // cycles since select went active
    int sel_cycles = 0;
    // early release point, well inside the transfer
    logic dropped;
    assign dropped = hs_drop && (sel_cycles >= 20);
    // count only while selected
    always_ff @(posedge clk) begin
        idle_bit <= ~idle_bit;
        sel_cycles <= chip_select_line_n ? 0 : sel_cycles + 1;
    end
    // inverted echo makes the received word predictable
    assign miso = chip_select_line_n ? idle_bit : ~mosi;
    assign slave_handshake_line_n = ~(hs_on && (chip_select_line_n ? hs_stuck : !dropped));
endmodule : spi_slave_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spi_cs_timing_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] FMT_BASE = 32'h0000_0308; // prescale 3, 8 bits
    localparam logic [31:0] FMT_SKIP = 32'h0004_0000;
    localparam logic [31:0] FMT_WAIT = 32'h0020_0000;
    localparam logic [31:0] FMT_PHASE = 32'h0001_0000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, cs_n, sclk, mosi, miso, hs_n;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic hs_on = 0, hs_stuck = 0, hs_drop = 0; // partner behaviour
    int errors = 0;
    int checked = 0;
    int cyc = 0, t_sel = 0, t_first = 0, t_last = 0, t_desel = 0, n_edges = 0;
    int s0, h0, dur;
    logic prev_cs = 1'b1, prev_sclk = 1'b0;

    initial begin
        forever #25 clk = ~clk;
    end

    spi_cs_timing u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chip_select_line_n(cs_n), .sclk(sclk), .mosi(mosi),
        .miso(miso), .slave_handshake_line_n(hs_n));

    spi_slave_model u_slave (.clk(clk), .chip_select_line_n(cs_n), .mosi(mosi),
        .hs_on(hs_on), .hs_stuck(hs_stuck), .hs_drop(hs_drop), .miso(miso),
        .slave_handshake_line_n(hs_n));

    // frame timing watcher, in system cycles, sampled mid-cycle
    always @(negedge clk) begin
        cyc++;
        if (prev_cs && !cs_n) begin
            t_sel = cyc;
            n_edges = 0;
        end
        // an edge that lands with the deselect still belongs to the frame
        if ((!cs_n || !prev_cs) && sclk !== prev_sclk) begin
            if (n_edges == 0)
                t_first = cyc;
            t_last = cyc;
            n_edges++;
        end
        if (!prev_cs && cs_n)
            t_desel = cyc;
        prev_cs = cs_n;
        prev_sclk = sclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one write; address and data offered together, held until taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr

    // one read; rready held until the answer is taken
    task automatic rd_reg(input logic [5:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd_reg

    task automatic expect_reg(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_reg(a);
        check(rd & m, e);
    endtask : expect_reg

    // program, send 0xA5, poll busy until select is back high
    task automatic frame(input logic [31:0] fmt, input logic [31:0] dly);
        wr(OFF_DELAYS, dly);
        wr(OFF_FMT0, fmt);
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_TXWORD, 32'h0000_00A5);
        do rd_reg(OFF_FLAGS); while (rd[FLG_BUSY_BIT] !== 1'b0);
    endtask : frame

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        expect_reg(OFF_RXBUF, ALL, 32'h8000_0000);
        expect_reg(OFF_DELAYS, ALL, DELAYS_RESET);
        expect_reg(OFF_FMT0, ALL, FMT_RESET);
        expect_reg(6'h3C, ALL, 32'h0);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(6'h1C, ALL);
        expect_reg(6'h1C, ALL, FMT_WMASK);
        wr(OFF_EMU, ALL);
        check({30'h0, resp}, {30'h0, RESP_OKAY});
        expect_reg(OFF_EMU, ALL, 32'h0);
        $display("test registers done");
        hs_on <= 1'b1;
        frame(FMT_BASE, 32'h0);
        s0 = t_first - t_sel;
        h0 = t_desel - t_last;
        check(n_edges, 16);
        frame(FMT_BASE, 32'h0503_0000);
        check(t_first - t_sel - s0, 7);
        check(t_desel - t_last - h0, 4);
        expect_reg(OFF_EMU, ALL, 32'h0000_005A);
        expect_reg(OFF_RXBUF, ALL, 32'h0000_005A);
        expect_reg(OFF_RXBUF, 32'h8000_0000, 32'h8000_0000);
        frame(FMT_BASE | FMT_SKIP, 32'h0503_0000);
        check(t_first - t_sel, s0);
        check(t_desel - t_last, h0);
        frame(FMT_BASE | FMT_PHASE, 32'h0);
        check(t_first - t_sel - s0, 4);
        check(h0 - (t_desel - t_last), 4);
        check(n_edges, 16);
        expect_reg(OFF_EMU, ALL, 32'h0000_005A);
        $display("test setup and hold done");
        hs_on <= 1'b0;
        frame(FMT_BASE | FMT_SKIP | FMT_WAIT, 32'h0000_0002);
        dur = t_desel - t_sel;
        check(n_edges, 0);
        check(dur >= 16 && dur <= 22, 1);
        expect_reg(OFF_FLAGS, 32'h3, 32'h1);
        expect_reg(OFF_RXBUF, 32'h0200_0000, 32'h0200_0000);
        frame(FMT_BASE | FMT_SKIP | FMT_WAIT, 32'h0000_0002);
        check(t_desel - t_sel, dur);
        wr(OFF_FLAGS, 32'h1);
        expect_reg(OFF_FLAGS, 32'h3, 32'h0);
        $display("test handshake timeout done");
        hs_on <= 1'b1;
        frame(FMT_BASE | FMT_SKIP | FMT_WAIT, 32'h0000_01FF);
        repeat (40) @(posedge clk);
        expect_reg(OFF_FLAGS, 32'h3, 32'h0);
        hs_stuck <= 1'b1;
        frame(FMT_BASE | FMT_SKIP | FMT_WAIT, 32'h0000_01FF);
        repeat (40) @(posedge clk);
        expect_reg(OFF_FLAGS, 32'h3, 32'h2);
        expect_reg(OFF_RXBUF, 32'h0800_0000, 32'h0800_0000);
        hs_stuck <= 1'b0;
        wr(OFF_FLAGS, 32'h3);
        hs_drop <= 1'b1;
        frame(FMT_BASE | FMT_SKIP | FMT_WAIT, 32'h0000_01FF);
        expect_reg(OFF_FLAGS, 32'h3, 32'h2);
        $display("test desync done");
        complete_run();
    end

    // hang guard, far beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
endmodule : testbench
`default_nettype wire
